// ### logic/sysctl_defines.svh
// Register offsets, field positions, reset values and timing counts for system control
// Assumes a 32-bit AHB-Lite slave with word-aligned registers
// Behaviour
// - PLL-lock raw flag, bit 6, sets when the PLL ready timer fires; resets to zero.
// - Current-limit raw flag, bit 5, sets when the regulator current limit asserts.
// - Interrupt output is the OR of raw flags ANDed with mask bits.
// - Mask bits 6..0 enable their raw flags; all reset to zero; bits 4,3 oscillator faults.
// - Regulator-unregulated raw flag, bit 2, sets when regulator is out of regulation.
// - PLL-fault raw flag, bit 0, sets when the PLL stops oscillating.
// - Brown-out raw flag, bit 1, sets on a detected brown-out.
// - Brown-out goes to reset when select bit is one, else to the interrupt flags.
// - Writing one to a masked status bit clears it and its raw flag; zero does nothing.
// - Reset cause bits: 5 regulator, 4 software, 3 watchdog, 2 brown-out, 1 power-on, 0 pin.
// - A pin reset sets the pin cause and clears all other causes.
// - Any other reset cause sets its flag and keeps earlier flags.
// - With auto gating set, sleep modes use sleep or deep-sleep gating registers, else run ones.
// - Run mode always uses the run-mode gating registers.
// - Divisor field 26:23 gives divide by code plus one for 1001..1111; reset 1111.
// - With the PLL in use the system clock is 200 MHz over the divisor.
// - A divisor written below the minimum while the PLL is used is stored as the minimum value.
// - Divisor enable bit 22 selects the divided clock; forced on while the PLL is used.
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

`define RAW_STATUS_OFFSET 12'h050
`define IRQ_MASK_OFFSET 12'h054
`define MASKED_STATUS_OFFSET 12'h058
`define RESET_CAUSE_OFFSET 12'h05c
`define RUN_CLOCK_OFFSET 12'h060
`define GATING_SELECT_OFFSET 12'h070

`define IRQ_BITS 7
`define BIT_PLL_LOCK 6
`define BIT_CURRENT_LIMIT 5
`define BIT_INT_OSC_FAULT 4
`define BIT_MAIN_OSC_FAULT 3
`define BIT_REGULATOR_UNREG 2
`define BIT_BROWNOUT 1
`define BIT_PLL_FAULT 0

`define CAUSE_BITS 6
`define CAUSE_REGULATOR 5
`define CAUSE_SOFTWARE 4
`define CAUSE_WATCHDOG 3
`define CAUSE_BROWNOUT 2
`define CAUSE_POWER_ON 1
`define CAUSE_PIN 0

`define AUTO_GATING_BIT 27
`define DIV_MSB 26
`define DIV_LSB 23
`define DIV_EN_BIT 22
`define DIV_RESET 4'hf
`define DIV_MIN_PLL 4'h9
`define MIN_DIV_DEFAULT 4'h9

`define PLL_OUT_MHZ 200
`define SYS_CLK_MHZ 20
`define DIV_CYCLE_COUNT (`PLL_OUT_MHZ / `SYS_CLK_MHZ)

`endif

// ### logic/sysctl_pkg.sv
// Types shared by the system control block
// Assumes the defines header is included alongside
package sysctl_pkg;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ = 3'b100
	} bus_state_t;

	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_SLEEP = 2'h1,
		MODE_DEEP_SLEEP = 2'h2
	} power_mode_t;

	typedef struct packed {
		logic pll_lock;
		logic current_limit;
		logic int_osc_fault;
		logic main_osc_fault;
		logic regulator_unreg;
		logic brownout;
		logic pll_fault;
	} irq_flags_t;

	typedef struct packed {
		logic regulator;
		logic software;
		logic watchdog;
		logic brownout;
		logic power_on;
		logic pin;
	} reset_causes_t;

	typedef struct packed {
		logic auto_clock_gating;
		logic [3:0] system_divisor;
		logic divisor_enable;
	} clock_config_t;

endpackage

// ### logic/sysctl_sync.sv
// Three-stage synchroniser for a group of pin-level inputs
// Assumes inputs are asynchronous to i_clk_sys; output changes when stages two and three agree
`timescale 1ns/10ps
`include "sysctl_defines.svh"

module sysctl_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
				if (!i_reset_n) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
					stage3[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					stage1[g] <= i_async[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					if (stage2[g] == stage3[g]) begin
						o_sync[g] <= stage3[g];
					end
				end
			end
		end
	endgenerate

endmodule

// ### logic/sysctl_gating.sv
// Peripheral clock enable selection between run, sleep and deep-sleep gating registers
// Assumes gating register words and power mode come from logic on the same clock
`timescale 1ns/10ps
`include "sysctl_defines.svh"

module sysctl_gating (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_auto_clock_gating,
	input wire sysctl_pkg::power_mode_t i_mode,
	input wire logic [31:0] i_run_gating_regs,
	input wire logic [31:0] i_sleep_gating_regs,
	input wire logic [31:0] i_deep_sleep_gating_regs,
	output logic [31:0] o_clock_enables
);

	wire in_sleep = (i_mode == sysctl_pkg::MODE_SLEEP);
	wire in_deep = (i_mode == sysctl_pkg::MODE_DEEP_SLEEP);
	wire [31:0] sleep_pick = in_deep ? i_deep_sleep_gating_regs : i_sleep_gating_regs;
	wire use_sleep_regs = i_auto_clock_gating && (in_sleep || in_deep);
	wire [31:0] next_enables = use_sleep_regs ? sleep_pick : i_run_gating_regs;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_clock_enables <= 32'h00000000;
		end else begin
			o_clock_enables <= next_enables;
		end
	end

endmodule

// ### logic/sysctl_top.sv
// System control: raw and masked event flags, reset cause, run-mode clock divisor and gating
// Assumes one AHB-Lite master, event inputs from pins or analog blocks, reset cause pulses on i_clk_sys
`timescale 1ns/10ps
`include "sysctl_defines.svh"

module sysctl_top (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_pll_ready_timer,
	input wire logic i_current_limit,
	input wire logic i_int_osc_fault,
	input wire logic i_main_osc_fault,
	input wire logic i_regulator_unreg,
	input wire logic i_brownout,
	input wire logic i_pll_fault,
	input wire logic i_brownout_reset_select,
	input wire logic i_pll_in_use,
	input wire logic i_cause_pin,
	input wire logic i_cause_power_on,
	input wire logic i_cause_brownout,
	input wire logic i_cause_watchdog,
	input wire logic i_cause_software,
	input wire logic i_cause_regulator,
	input wire sysctl_pkg::power_mode_t i_mode,
	input wire logic [31:0] i_run_gating_regs,
	input wire logic [31:0] i_sleep_gating_regs,
	input wire logic [31:0] i_deep_sleep_gating_regs,
	output logic o_irq,
	output logic o_brownout_reset_req,
	output logic o_sys_clk_en,
	output logic o_use_divider,
	output logic [31:0] o_clock_enables
);

	sysctl_pkg::irq_flags_t raw_flags;
	sysctl_pkg::irq_flags_t mask;
	sysctl_pkg::reset_causes_t causes;
	sysctl_pkg::clock_config_t clk_cfg;
	sysctl_pkg::bus_state_t bus_state;
	logic [11:0] addr_q;
	logic [3:0] div_count;
	logic [3:0] minimum_divisor;
	logic [`IRQ_BITS-1:0] sync_events;

	// Pin-level event inputs are asynchronous
	sysctl_sync #(
		.WIDTH(`IRQ_BITS)
	) u_event_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_async({i_pll_ready_timer, i_current_limit, i_int_osc_fault, i_main_osc_fault,
			i_regulator_unreg, i_brownout, i_pll_fault}),
		.o_sync(sync_events)
	);

	sysctl_gating u_gating (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_auto_clock_gating(clk_cfg.auto_clock_gating),
		.i_mode(i_mode),
		.i_run_gating_regs(i_run_gating_regs),
		.i_sleep_gating_regs(i_sleep_gating_regs),
		.i_deep_sleep_gating_regs(i_deep_sleep_gating_regs),
		.o_clock_enables(o_clock_enables)
	);

	// Bus address phase decode
	wire addr_phase = i_hsel && i_hready && i_htrans[1];
	wire wr_active = (bus_state == sysctl_pkg::BUS_WRITE);
	wire sel_mask = (addr_q == `IRQ_MASK_OFFSET);
	wire sel_masked = (addr_q == `MASKED_STATUS_OFFSET);
	wire sel_cause = (addr_q == `RESET_CAUSE_OFFSET);
	wire sel_clock = (addr_q == `RUN_CLOCK_OFFSET);
	wire sel_min = (addr_q == `GATING_SELECT_OFFSET);

	// Write strobes in the data phase; raw status takes no writes
	wire wr_mask = wr_active && sel_mask;
	wire wr_masked = wr_active && sel_masked;
	wire wr_cause = wr_active && sel_cause;
	wire wr_clock = wr_active && sel_clock;
	wire wr_min = wr_active && sel_min;

	// Read decode straight from the address phase
	wire rd_take = addr_phase && !i_hwrite;
	wire [11:0] rd_addr = i_haddr[11:0];
	wire rsel_raw = (rd_addr == `RAW_STATUS_OFFSET);
	wire rsel_mask = (rd_addr == `IRQ_MASK_OFFSET);
	wire rsel_masked = (rd_addr == `MASKED_STATUS_OFFSET);
	wire rsel_cause = (rd_addr == `RESET_CAUSE_OFFSET);
	wire rsel_clock = (rd_addr == `RUN_CLOCK_OFFSET);
	wire rsel_min = (rd_addr == `GATING_SELECT_OFFSET);

	// Brown-out routing: reset path or interrupt path
	wire bo_to_irq = sync_events[`BIT_BROWNOUT] && !i_brownout_reset_select;
	wire bo_to_reset = sync_events[`BIT_BROWNOUT] && i_brownout_reset_select;

	// Hardware set sources for each raw flag
	wire [`IRQ_BITS-1:0] set_flags = {
		sync_events[`BIT_PLL_LOCK],
		sync_events[`BIT_CURRENT_LIMIT],
		sync_events[`BIT_INT_OSC_FAULT],
		sync_events[`BIT_MAIN_OSC_FAULT],
		sync_events[`BIT_REGULATOR_UNREG],
		bo_to_irq,
		sync_events[`BIT_PLL_FAULT]
	};

	// Masked view; drives both the read-back and the interrupt
	wire [`IRQ_BITS-1:0] masked = raw_flags & mask;

	// Write-one-to-clear on masked bits only; a set in the same cycle wins
	wire [`IRQ_BITS-1:0] clear_flags = wr_masked ?
		(i_hwdata[`IRQ_BITS-1:0] & masked) : {`IRQ_BITS{1'b0}};
	wire [`IRQ_BITS-1:0] next_raw = (raw_flags & ~clear_flags) | set_flags;

	// Divisor clamp when the PLL drives the clock
	wire [3:0] req_div = i_hwdata[`DIV_MSB:`DIV_LSB];
	wire [3:0] next_div = (i_pll_in_use && (req_div < minimum_divisor)) ? minimum_divisor : req_div;
	wire div_in_use = clk_cfg.divisor_enable || i_pll_in_use;
	wire div_wrap = (div_count >= clk_cfg.system_divisor);

	// Reset cause update: pin reset wipes the rest, others accumulate
	wire [5:0] cause_other = {i_cause_regulator, i_cause_software, i_cause_watchdog,
		i_cause_brownout, i_cause_power_on, 1'b0};

	// Read multiplexer; unmapped addresses read zero
	wire [31:0] rd_raw = {25'h0000000, raw_flags};
	wire [31:0] rd_mask = {25'h0000000, mask};
	wire [31:0] rd_masked = {25'h0000000, masked};
	wire [31:0] rd_cause = {26'h0000000, causes};
	wire [31:0] rd_clock = {4'h0, clk_cfg.auto_clock_gating, clk_cfg.system_divisor,
		clk_cfg.divisor_enable, 22'h000000};
	wire [31:0] rd_min = {28'h0000000, minimum_divisor};
	wire [31:0] next_rdata = rsel_raw ? rd_raw :
		rsel_mask ? rd_mask :
		rsel_masked ? rd_masked :
		rsel_cause ? rd_cause :
		rsel_clock ? rd_clock :
		rsel_min ? rd_min : 32'h00000000;

	// Bus state: one data-phase cycle, always ready and OKAY
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus_state <= sysctl_pkg::BUS_IDLE;
			addr_q <= 12'h000;
		end else begin
			case (bus_state)
				sysctl_pkg::BUS_IDLE,
				sysctl_pkg::BUS_WRITE,
				sysctl_pkg::BUS_READ: begin
					if (addr_phase) begin
						bus_state <= i_hwrite ? sysctl_pkg::BUS_WRITE : sysctl_pkg::BUS_READ;
						addr_q <= i_haddr[11:0];
					end else begin
						bus_state <= sysctl_pkg::BUS_IDLE;
					end
				end
				default: begin
					bus_state <= sysctl_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Read data registered at the address phase so it stands in the data phase
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			// A read overlapping a write's data phase returns the value before that write
			if (rd_take) begin
				o_hrdata <= next_rdata;
			end
		end
	end

	// Raw flags, one flop per bit
	genvar b;
	generate
		for (b = 0; b < `IRQ_BITS; b++) begin : g_raw
			always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
				if (!i_reset_n) begin
					raw_flags[b] <= 1'b0;
				end else begin
					raw_flags[b] <= next_raw[b];
				end
			end
		end
	endgenerate

	// Interrupt masks
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mask <= '0;
		end else begin
			if (wr_mask) begin
				mask <= i_hwdata[`IRQ_BITS-1:0];
			end
		end
	end

	// Interrupt output
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
			o_brownout_reset_req <= 1'b0;
		end else begin
			o_irq <= |masked;
			o_brownout_reset_req <= bo_to_reset;
		end
	end

	// Reset cause capture: pulses on i_cause_* mark a reset just taken
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			causes <= '0;
		end else begin
			if (i_cause_pin) begin
				causes <= 6'h01;
			end else if (|cause_other) begin
				causes <= causes | cause_other;
			end else if (wr_cause) begin
				causes <= i_hwdata[`CAUSE_BITS-1:0];
			end
		end
	end

	// Run-mode clock configuration
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_cfg.auto_clock_gating <= 1'b0;
			clk_cfg.system_divisor <= `DIV_RESET;
			clk_cfg.divisor_enable <= 1'b0;
			minimum_divisor <= `MIN_DIV_DEFAULT;
		end else begin
			if (wr_clock) begin
				clk_cfg.auto_clock_gating <= i_hwdata[`AUTO_GATING_BIT];
				clk_cfg.system_divisor <= next_div;
				clk_cfg.divisor_enable <= i_hwdata[`DIV_EN_BIT];
			end
			if (wr_min) begin
				minimum_divisor <= i_hwdata[3:0];
			end
		end
	end

	// System clock enable: one pulse per divisor+1 cycles of the reference while divided, every cycle otherwise
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_count <= 4'h0;
			o_sys_clk_en <= 1'b0;
			o_use_divider <= 1'b0;
		end else begin
			o_use_divider <= div_in_use;
			if (!div_in_use) begin
				div_count <= 4'h0;
				o_sys_clk_en <= 1'b1;
			end else if (div_wrap) begin
				div_count <= 4'h0;
				o_sys_clk_en <= 1'b1;
			end else begin
				div_count <= div_count + 4'h1;
				o_sys_clk_en <= 1'b0;
			end
		end
	end

endmodule

// ### tb/event_source.sv
// Partner model: the monitors that raise raw fault and event lines
// Assumes one-cycle fire requests on the system clock, bits in raw status order
`timescale 1ns/10ps
module event_source (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [6:0] i_fire,
	output logic [6:0] o_events
);
	logic [2:0] hold [7];
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		for (int i = 0; i < 7; i++) begin
			if (!i_reset_n) begin
				hold[i] <= 3'h0;
				o_events[i] <= 1'b0;
			end else begin
				// A line stands six cycles, enough for the input synchroniser
				hold[i] <= i_fire[i] ? 3'h6 : hold[i] - {2'h0, hold[i] != 3'h0};
				o_events[i] <= i_fire[i] || hold[i] > 3'h1;
			end
		end
	end
endmodule

// ### tb/sysctl_top_asserts.sv
// Port checker for the system control block
// Assumes one clock domain; bound to sysctl_top at the foot
`timescale 1ns/10ps
module sysctl_top_asserts (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_brownout,
	input wire logic i_brownout_reset_select,
	input wire logic i_pll_in_use,
	input wire sysctl_pkg::power_mode_t i_mode,
	input wire logic [31:0] i_run_gating_regs,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_irq,
	input wire logic o_brownout_reset_req,
	input wire logic o_sys_clk_en,
	input wire logic o_use_divider,
	input wire logic [31:0] o_clock_enables
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	property p_bus_okay; o_hreadyout && !o_hresp; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
	property p_irq_rst; $rose(i_reset_n) |-> !o_irq [*3]; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
	property p_use_div; i_pll_in_use [*2] |-> o_use_divider; endproperty
	a_use_div: assert property (p_use_div) else $error("divider not forced");
	property p_clk_const; !o_use_divider [*3] |-> o_sys_clk_en; endproperty
	a_clk_const: assert property (p_clk_const) else $error("clock enable gaps");
	property p_clk_gap; o_use_divider [*4] ##0 o_sys_clk_en ##1 o_use_divider |-> !o_sys_clk_en; endproperty
	a_clk_gap: assert property (p_clk_gap) else $error("divided enable twice");
	property p_bo_req; (i_brownout && i_brownout_reset_select) [*6] |-> o_brownout_reset_req; endproperty
	a_bo_req: assert property (p_bo_req) else $error("no brownout reset");
	property p_bo_sel; o_brownout_reset_req |-> $past(i_brownout_reset_select); endproperty
	a_bo_sel: assert property (p_bo_sel) else $error("reset without select");
	property p_run_gate;
		((i_mode == sysctl_pkg::MODE_RUN) && $stable(i_run_gating_regs)) [*3] |-> o_clock_enables == i_run_gating_regs;
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("run gating not used");
endmodule
bind sysctl_top sysctl_top_asserts u_asserts (.i_clk_sys, .i_reset_n, .i_brownout, .i_brownout_reset_select,
	.i_pll_in_use, .i_mode, .i_run_gating_regs, .o_hreadyout, .o_hresp, .o_irq, .o_brownout_reset_req,
	.o_sys_clk_en, .o_use_divider, .o_clock_enables);

// ### tb/tb.sv
// Testbench for sysctl_top: register bus, events, reset causes, divisor, gating
// Assumes event_source as partner and the bound port checker
`timescale 1ns/10ps
module tb;
	logic i_clk_sys, i_reset_n, i_hsel, i_hwrite, i_brownout_reset_select, i_pll_in_use;
	logic [31:0] i_haddr, i_hwdata, i_run_gating_regs, i_sleep_gating_regs, i_deep_sleep_gating_regs;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	logic [6:0] fire;
	logic [5:0] cause;
	sysctl_pkg::power_mode_t i_mode;
	wire i_pll_ready_timer, i_current_limit, i_int_osc_fault, i_main_osc_fault, i_regulator_unreg;
	wire i_brownout, i_pll_fault, o_hreadyout, o_hresp, o_irq, o_brownout_reset_req, o_sys_clk_en, o_use_divider;
	wire [31:0] o_hrdata, o_clock_enables;
	int errors, samples_checked;
	sysctl_top u_dut (.i_clk_sys, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
		.i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_pll_ready_timer, .i_current_limit,
		.i_int_osc_fault, .i_main_osc_fault, .i_regulator_unreg, .i_brownout, .i_pll_fault,
		.i_brownout_reset_select, .i_pll_in_use, .i_cause_pin(cause[0]), .i_cause_power_on(cause[1]),
		.i_cause_brownout(cause[2]), .i_cause_watchdog(cause[3]), .i_cause_software(cause[4]),
		.i_cause_regulator(cause[5]), .i_mode, .i_run_gating_regs, .i_sleep_gating_regs,
		.i_deep_sleep_gating_regs, .o_irq, .o_brownout_reset_req, .o_sys_clk_en, .o_use_divider, .o_clock_enables);
	event_source u_events (.i_clk_sys, .i_reset_n, .i_fire(fire), .o_events({i_pll_ready_timer, i_current_limit,
		i_int_osc_fault, i_main_osc_fault, i_regulator_unreg, i_brownout, i_pll_fault}));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge i_clk_sys);
		n++;
		if (n > 60) begin
			errors++;
			print_verdict();
		end
	endtask
	// Reserved bits are always written as zero
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		i_haddr <= {20'h0, a};
		do tick(n); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do tick(n); while (o_hreadyout !== 1'b1);
		q = o_hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic pulse(input logic [6:0] f, input logic [5:0] c);
		@(posedge i_clk_sys);
		fire <= f;
		cause <= c;
		@(posedge i_clk_sys);
		fire <= 7'h00;
		cause <= 6'h00;
	endtask
	task automatic period(input logic [31:0] exp);
		int n;
		for (int j = 0; j < 3; j++) begin
			n = 0;
			do tick(n); while (o_sys_clk_en !== 1'b1);
		end
		check(n, exp);
	endtask
	task automatic t_reset_vals();
		rdc(12'h054, 32'h0);
		rdc(12'h058, 32'h0);
		rdc(12'h050, 32'h0);
		rdc(12'h060, 32'h0780_0000);
		rdc(12'h0f0, 32'h0);
	endtask
	task automatic t_events();
		logic [31:0] m;
		for (int i = 0; i < 7; i++) begin
			m = 32'h1 << i;
			wr(12'h054, m);
			pulse(m[6:0], 6'h00);
			repeat (8) @(posedge i_clk_sys);
			rdc(12'h050, m);
			check({31'h0, o_irq}, 32'h1);
			wr(12'h058, 32'h0);
			rdc(12'h058, m);
			wr(12'h058, m);
			rdc(12'h050, 32'h0);
			check({31'h0, o_irq}, 32'h0);
		end
	endtask
	task automatic t_blocked();
		wr(12'h054, 32'h0);
		pulse(7'h20, 6'h00);
		repeat (8) @(posedge i_clk_sys);
		check({31'h0, o_irq}, 32'h0);
		wr(12'h058, 32'h20);
		rdc(12'h050, 32'h20);
		wr(12'h054, 32'h7f);
		rdc(12'h054, 32'h7f);
		check({31'h0, o_irq}, 32'h1);
		wr(12'h058, 32'h20);
		rdc(12'h058, 32'h0);
	endtask
	task automatic t_brownout_reset();
		i_brownout_reset_select <= 1'b1;
		pulse(7'h02, 6'h00);
		repeat (7) @(posedge i_clk_sys);
		check({31'h0, o_brownout_reset_req}, 32'h1);
		repeat (8) @(posedge i_clk_sys);
		i_brownout_reset_select <= 1'b0;
		rdc(12'h050, 32'h0);
		check({31'h0, o_irq}, 32'h0);
	endtask
	task automatic t_cause();
		wr(12'h05c, 32'h0);
		rdc(12'h05c, 32'h0);
		for (int i = 1; i < 6; i++) begin
			pulse(7'h00, 6'h01 << i);
			rdc(12'h05c, (32'h2 << i) - 32'h2);
		end
		pulse(7'h00, 6'h01);
		rdc(12'h05c, 32'h1);
		wr(12'h05c, 32'h24);
		rdc(12'h05c, 32'h24);
	endtask
	task automatic t_clock();
		for (int c = 9; c < 16; c++) begin
			wr(12'h060, (32'(c) << 23) | 32'h0040_0000);
			rdc(12'h060, (32'(c) << 23) | 32'h0040_0000);
			check({31'h0, o_use_divider}, 32'h1);
			period(32'(c) + 32'h1);
		end
		i_pll_in_use <= 1'b1;
		wr(12'h060, 32'h0180_0000);
		rdc(12'h060, 32'h0480_0000);
		period(32'ha);
		wr(12'h070, 32'hc);
		rdc(12'h070, 32'hc);
		wr(12'h060, 32'h0500_0000);
		rdc(12'h060, 32'h0600_0000);
		period(32'hd);
		i_pll_in_use <= 1'b0;
		wr(12'h060, 32'h0180_0000);
		rdc(12'h060, 32'h0180_0000);
		check({31'h0, o_use_divider}, 32'h0);
	endtask
	task automatic t_gating();
		wr(12'h060, 32'h0f80_0000);
		for (int m = 0; m < 3; m++) begin
			i_mode <= sysctl_pkg::power_mode_t'(m);
			repeat (3) @(posedge i_clk_sys);
			check(o_clock_enables, 32'h11 << (4 * m));
		end
		wr(12'h060, 32'h0780_0000);
		repeat (3) @(posedge i_clk_sys);
		check(o_clock_enables, 32'h11);
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_reset_n = 1'b0;
		i_hsel = 1'b1;
		i_hsize = 3'h2;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_haddr = 32'h0;
		i_hwdata = 32'h0;
		i_brownout_reset_select = 1'b0;
		i_pll_in_use = 1'b0;
		fire = 7'h00;
		cause = 6'h00;
		i_mode = sysctl_pkg::MODE_RUN;
		i_run_gating_regs = 32'h11;
		i_sleep_gating_regs = 32'h110;
		i_deep_sleep_gating_regs = 32'h1100;
		repeat (12) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		@(posedge i_clk_sys);
		t_reset_vals();
		t_events();
		t_blocked();
		t_brownout_reset();
		t_cause();
		t_clock();
		t_gating();
		print_verdict();
	end
endmodule
